// >>> design/icch_device.sv
// Device end: decodes and executes interface configuration commands.
//
// Decided for this implementation: the placing of the registers and the Wishbone slave port.
`include "icch_cfg.svh"
`default_nettype none
module icch_device (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Command link
  icch_if.dev lnk,
  // System status
  input wire logic ack_enable,
  input wire logic [31:0] pin_in_use,
  input wire logic [31:0] pin_gpio_ok,
  input wire logic [15:0] mem_avail,
  input wire logic net_up,
  // UART configuration, index 0 is the first port
  output logic [1:0] uart_interface_enable,
  output logic [1:0] uart_parity_on,
  output logic [1:0] uart_parity_odd,
  output logic [1:0] uart_two_stop,
  output logic [1:0] uart_flow_control_enable,
  output logic [23:0] uart0_baud,
  output logic [23:0] first_uart_port_baud,
  // SPI configuration
  output logic spi_interface_enable,
  output logic spi_idle_high,
  output logic spi_sample_second,
  output logic [7:0] spi_pending_pin,
  // Multicast configuration
  output logic [15:0] mcast_group_count,
  output logic [7:0] mcast_addr_fields,
  // System reset request
  output logic sys_reset_req
);
  icch_pkg::icch_dev_t r;
  icch_pkg::icch_dev_t n;
  logic [31:0] word;
  logic asm_clr;
  logic asm_load;

  // ****************************************************************
  // Pin conflict search
  // ****************************************************************
  function automatic logic [8:0] icch_first_busy(input logic [31:0] pins, input logic [3:0] need,
                                                 input logic [31:0] used);
    logic [8:0] res;
    logic [7:0] p;
    res = 9'h000;
    for (int i = 3; i >= 0; i--) begin
      p = pins[8*i +: 8];
      if (!res[8] && need[3-i] && p < 8'h20 && used[p[4:0]]) begin
        res = {1'b1, p};
      end
    end
    return res;
  endfunction : icch_first_busy

  // ****************************************************************
  // Argument assembly
  // ****************************************************************
  assign asm_clr = r.st == icch_pkg::DEV_IDLE && lnk.h2d_valid && lnk.h2d_first;
  assign asm_load = r.st == icch_pkg::DEV_IDLE && lnk.h2d_valid && !lnk.h2d_first && r.nargs < 3'h4;

  icch_le_asm u_asm (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clr(asm_clr),
    .load(asm_load),
    .idx(r.nargs[1:0]),
    .din(lnk.h2d_data),
    .word(word)
  );

  // ****************************************************************
  // Command engine
  // ****************************************************************
  always_comb begin
    logic [7:0] code;
    logic [8:0] hit;
    logic [7:0] cfgb;
    logic [7:0] pend;
    logic [16:0] need;
    logic u;
    logic en;
    logic fact;
    code = `ICCH_RC_OK;
    hit = 9'h000;
    cfgb = word[7:0];
    pend = word[15:8];
    need = 17'h00000;
    u = r.cmd == `ICCH_CMD_SECOND_UART_PORT;
    en = cfgb[`ICCH_BIT_ENABLE];
    fact = 1'b0;
    n = r;
    n.tx_valid = 1'b0;
    n.tx_last = 1'b0;
    n.sys_reset = 1'b0;
    unique case (r.st)
      icch_pkg::DEV_IDLE: begin
        if (lnk.h2d_valid) begin
          if (lnk.h2d_first) begin
            n.cmd = lnk.h2d_data;
            n.nargs = 3'h0;
          end else if (r.nargs != 3'h7) begin
            n.nargs = r.nargs + 3'h1;
          end
          if (lnk.h2d_last) begin
            n.st = icch_pkg::DEV_EXEC;
          end
        end
      end
      icch_pkg::DEV_EXEC: begin
        n.rsp_cmd = r.cmd;
        n.rsp_haspin = 1'b0;
        n.rsp_pin = 8'h00;
        n.rsp_idx = 2'h0;
        n.st = icch_pkg::DEV_IDLE;
        if (r.cmd == `ICCH_CMD_FIRST_UART_PORT || r.cmd == `ICCH_CMD_SECOND_UART_PORT) begin
          hit = icch_first_busy(u ? `ICCH_U1_PINS : `ICCH_U0_PINS,
                                {en, en, en & cfgb[`ICCH_BIT_FLOW], en & cfgb[`ICCH_BIT_FLOW]}, pin_in_use);
          if (r.nargs == 3'h0 || (r.nargs < `ICCH_UART_LEN && (en || r.nargs > 3'h1))) begin
            code = `ICCH_RC_SHORT;
          end else if (r.nargs > `ICCH_UART_LEN) begin
            code = `ICCH_RC_LONG;
          end else if (hit[8]) begin
            code = `ICCH_RC_PINBUSY;
            n.rsp_pin = hit[7:0];
            n.rsp_haspin = 1'b1;
          end else begin
            n.ucfg[u] = cfgb;
            if (r.nargs == `ICCH_UART_LEN) begin
              n.baud[u] = word[31:8];
            end
          end
        end else if (r.cmd == `ICCH_CMD_SPI) begin
          hit = icch_first_busy(`ICCH_SPI_PINS, {4{en}}, pin_in_use);
          if (r.nargs == 3'h0 || (en && r.nargs < `ICCH_SPI_LEN)) begin
            code = `ICCH_RC_SHORT;
          end else if (r.nargs > `ICCH_SPI_LEN) begin
            code = `ICCH_RC_LONG;
          end else if (en && (pend > 8'h1F || !pin_gpio_ok[pend[4:0]])) begin
            code = `ICCH_RC_NOTGPIO;
            n.rsp_pin = pend;
            n.rsp_haspin = 1'b1;
          end else if (en && (hit[8] || pin_in_use[pend[4:0]])) begin
            code = `ICCH_RC_PINBUSY;
            n.rsp_pin = hit[8] ? hit[7:0] : pend;
            n.rsp_haspin = 1'b1;
          end else begin
            n.spi_cfg = cfgb;
            if (r.nargs == `ICCH_SPI_LEN) begin
              n.pend_pin = pend;
            end
          end
        end else if (r.cmd == `ICCH_CMD_FACTORY) begin
          if (r.nargs < `ICCH_FACT_LEN) begin
            code = `ICCH_RC_SHORT;
          end else if (r.nargs > `ICCH_FACT_LEN) begin
            code = `ICCH_RC_LONG;
          end else if (word != `ICCH_FACT_KEY) begin
            code = `ICCH_RC_BADVAL;
          end else begin
            fact = 1'b1;
            n.ucfg = {2{`ICCH_RST_UART_CFG}};
            n.baud = {2{`ICCH_RST_BAUD}};
            n.spi_cfg = `ICCH_RST_SPI_CFG;
            n.pend_pin = `ICCH_RST_PEND_PIN;
            n.grp_cnt = `ICCH_RST_GRP_CNT;
            n.grp_fields = `ICCH_RST_GRP_FIELDS;
            n.sys_reset = 1'b1;
            n.rsp_cmd = `ICCH_RPT_RESET;
            code = `ICCH_RC_RESET;
          end
        end else if (r.cmd == `ICCH_CMD_MCAST) begin
          need = ({1'b0, word[15:0]} + `ICCH_GRP_PER_BYTE - 17'h00001) / `ICCH_GRP_PER_BYTE;
          if (r.nargs < `ICCH_MCAST_LEN) begin
            code = `ICCH_RC_SHORT;
          end else if (r.nargs > `ICCH_MCAST_LEN) begin
            code = `ICCH_RC_LONG;
          end else if (word[15:0] > `ICCH_GRP_MAX) begin
            code = `ICCH_RC_GRPCNT;
          end else if (word[23:16] == 8'h00 || word[23:16] > `ICCH_GRP_FIELDS_MAX) begin
            code = `ICCH_RC_GRPFLD;
          end else if (need > {1'b0, mem_avail}) begin
            code = `ICCH_RC_NOMEM;
            n.sys_reset = 1'b1;
          end else begin
            n.grp_cnt = word[15:0];
            n.grp_fields = word[23:16];
          end
        end
        // Unknown command codes belong to other handlers and are dropped.
        n.rsp_code = code;
        // A valid restore answers with code 3 but must keep the defaults it has just loaded.
        if (code != `ICCH_RC_OK && !fact) begin
          n.ucfg = r.ucfg;
          n.baud = r.baud;
          n.spi_cfg = r.spi_cfg;
          n.pend_pin = r.pend_pin;
          n.grp_cnt = r.grp_cnt;
          n.grp_fields = r.grp_fields;
        end
        if (fact || code != `ICCH_RC_OK || (ack_enable && (r.cmd == `ICCH_CMD_FIRST_UART_PORT ||
            r.cmd == `ICCH_CMD_SECOND_UART_PORT || r.cmd == `ICCH_CMD_SPI || r.cmd == `ICCH_CMD_MCAST))) begin
          n.st = icch_pkg::DEV_RESP;
        end
        if (!(r.cmd >= `ICCH_CMD_FIRST_UART_PORT && r.cmd <= `ICCH_CMD_MCAST)) begin
          n.st = icch_pkg::DEV_IDLE;
        end
      end
      icch_pkg::DEV_RESP: begin
        n.tx_valid = 1'b1;
        n.tx_data = r.rsp_idx == 2'h0 ? r.rsp_cmd : (r.rsp_idx == 2'h1 ? r.rsp_code : r.rsp_pin);
        n.tx_last = r.rsp_idx == 2'h2 || (r.rsp_idx == 2'h1 && !r.rsp_haspin);
        n.rsp_idx = r.rsp_idx + 2'h1;
        if (n.tx_last) begin
          n.st = r.rsp_cmd == `ICCH_RPT_RESET ? icch_pkg::DEV_NETW : icch_pkg::DEV_IDLE;
        end
      end
      icch_pkg::DEV_NETW: begin
        // The notice waits for the network stack, so a stalled stack holds off new commands.
        if (net_up) begin
          n.rsp_cmd = `ICCH_RPT_NETCFG;
          n.rsp_code = `ICCH_RC_OK;
          n.rsp_haspin = 1'b0;
          n.rsp_idx = 2'h0;
          n.st = icch_pkg::DEV_RESP;
        end
      end
      default: begin
        n.st = icch_pkg::DEV_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '{st: icch_pkg::DEV_IDLE, ucfg: {2{`ICCH_RST_UART_CFG}}, baud: {2{`ICCH_RST_BAUD}},
             spi_cfg: `ICCH_RST_SPI_CFG, pend_pin: `ICCH_RST_PEND_PIN, grp_cnt: `ICCH_RST_GRP_CNT,
             grp_fields: `ICCH_RST_GRP_FIELDS, default: '0};
    end else begin
      r <= n;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign lnk.d2h_valid = r.tx_valid;
  assign lnk.d2h_last = r.tx_last;
  assign lnk.d2h_data = r.tx_data;
  assign uart_interface_enable = {r.ucfg[1][`ICCH_BIT_ENABLE], r.ucfg[0][`ICCH_BIT_ENABLE]};
  assign uart_parity_on = {r.ucfg[1][`ICCH_BIT_PAR_ON], r.ucfg[0][`ICCH_BIT_PAR_ON]};
  assign uart_parity_odd = {r.ucfg[1][`ICCH_BIT_PAR_ODD], r.ucfg[0][`ICCH_BIT_PAR_ODD]};
  assign uart_two_stop = {r.ucfg[1][`ICCH_BIT_STOP], r.ucfg[0][`ICCH_BIT_STOP]};
  assign uart_flow_control_enable = {r.ucfg[1][`ICCH_BIT_FLOW], r.ucfg[0][`ICCH_BIT_FLOW]};
  assign uart0_baud = r.baud[0];
  assign first_uart_port_baud = r.baud[1];
  assign spi_interface_enable = r.spi_cfg[`ICCH_BIT_ENABLE];
  assign spi_idle_high = r.spi_cfg[`ICCH_BIT_CPOL];
  assign spi_sample_second = r.spi_cfg[`ICCH_BIT_CPHA];
  assign spi_pending_pin = r.pend_pin;
  assign mcast_group_count = r.grp_cnt;
  assign mcast_addr_fields = r.grp_fields;
  assign sys_reset_req = r.sys_reset;
endmodule : icch_device
`default_nettype wire

// >>> design/icch_cfg.svh
// Constants for the interface configuration command handler.
// Behaviour
// - UART command: config byte, three baud bytes.
// - Baud bytes travel least significant first.
// - Disabled UART command may omit baud bytes.
// - Config bit 0 enables the port.
// - Parity bits 5:4: 0 none, 2 even, 3 odd.
// - UART bit 6 selects two stop bits.
// - UART bit 7 enables hardware flow control.
// - Success answers code 0 only with acknowledges.
// - Code 1 too short, code 2 too long.
// - Busy needed pin answers code 9 with pin.
// - Second UART behaves exactly like the first.
// - SPI command: config byte, pending pin optional only when disabled.
// - SPI CPHA bit 5, CPOL bit 4, enable bit 0.
// - CPOL one means clock idles high.
// - CPHA one samples on second edge.
// - Restore needs word 0xF85A23E1, else code 7.
// - Valid restore reinstates defaults, resets, never acknowledges.
// - After restore: report code 3, then network notice.
// - Multicast: two-byte group count, one-byte field count.
// - Groups count from one; group zero invalid. The code accepts a group count of zero.
// - Memory short code 5, count 10, fields 11.
`ifndef ICCH_CFG_SVH
`define ICCH_CFG_SVH
// ****************************************************************
// Command and report identifiers
// ****************************************************************
`define ICCH_CMD_FIRST_UART_PORT 8'h30
`define ICCH_CMD_SECOND_UART_PORT 8'h31
`define ICCH_CMD_SPI 8'h32
`define ICCH_CMD_FACTORY 8'h33
`define ICCH_CMD_MCAST 8'h34
`define ICCH_RPT_RESET 8'h40
`define ICCH_RPT_NETCFG 8'h41
// ****************************************************************
// Response codes
// ****************************************************************
`define ICCH_RC_OK 8'h00
`define ICCH_RC_SHORT 8'h01
`define ICCH_RC_LONG 8'h02
`define ICCH_RC_RESET 8'h03
`define ICCH_RC_NOMEM 8'h05
`define ICCH_RC_BADVAL 8'h07
`define ICCH_RC_NOTGPIO 8'h08
`define ICCH_RC_PINBUSY 8'h09
`define ICCH_RC_GRPCNT 8'h0A
`define ICCH_RC_GRPFLD 8'h0B
// ****************************************************************
// Field positions, lengths and limits
// ****************************************************************
`define ICCH_BIT_ENABLE 0
`define ICCH_BIT_PAR_ON 5
`define ICCH_BIT_PAR_ODD 4
`define ICCH_BIT_STOP 6
`define ICCH_BIT_FLOW 7
`define ICCH_BIT_CPHA 5
`define ICCH_BIT_CPOL 4
`define ICCH_UART_LEN 3'h4
`define ICCH_SPI_LEN 3'h2
`define ICCH_FACT_LEN 3'h4
`define ICCH_MCAST_LEN 3'h3
`define ICCH_FACT_KEY 32'hF85A23E1
`define ICCH_GRP_MAX 16'h0400
`define ICCH_GRP_FIELDS_MAX 8'h08
`define ICCH_GRP_PER_BYTE 17'h00008
// ****************************************************************
// Pin assignment and reset values
// ****************************************************************
`define ICCH_U0_PINS {8'h00, 8'h01, 8'h02, 8'h03}
`define ICCH_U1_PINS {8'h04, 8'h05, 8'h06, 8'h07}
`define ICCH_SPI_PINS {8'h08, 8'h09, 8'h0A, 8'h0B}
`define ICCH_RST_UART_CFG 8'h01
`define ICCH_RST_BAUD 24'h01C200
`define ICCH_RST_SPI_CFG 8'h00
`define ICCH_RST_PEND_PIN 8'h0C
`define ICCH_RST_GRP_CNT 16'h0008
`define ICCH_RST_GRP_FIELDS 8'h01
// ****************************************************************
// Host register map
// ****************************************************************
`define ICCH_ADR_CTRL 8'h00
`define ICCH_ADR_ARG 8'h04
`define ICCH_ADR_STATUS 8'h08
`endif

// >>> design/icch_pkg.sv
// Types shared by both ends of the configuration command link.
`default_nettype none
package icch_pkg;
  typedef enum logic [4:0] {
    DEV_IDLE = 5'h01,
    DEV_EXEC = 5'h02,
    DEV_RESP = 5'h04,
    DEV_NETW = 5'h08,
    DEV_SPARE = 5'h10
  } icch_dev_st_t;

  typedef enum logic [1:0] {
    HOST_IDLE = 2'h1,
    HOST_SEND = 2'h2
  } icch_host_st_t;

  typedef struct packed {
    icch_dev_st_t st;
    logic [7:0] cmd;
    logic [2:0] nargs;
    logic [1:0][7:0] ucfg;
    logic [1:0][23:0] baud;
    logic [7:0] spi_cfg;
    logic [7:0] pend_pin;
    logic [15:0] grp_cnt;
    logic [7:0] grp_fields;
    logic [7:0] rsp_cmd;
    logic [7:0] rsp_code;
    logic [7:0] rsp_pin;
    logic rsp_haspin;
    logic [1:0] rsp_idx;
    logic tx_valid;
    logic tx_last;
    logic [7:0] tx_data;
    logic sys_reset;
  } icch_dev_t;

  typedef struct packed {
    icch_host_st_t st;
    logic [7:0] cmd;
    logic [2:0] nargs;
    logic [31:0] arg;
    logic [2:0] idx;
    logic tx_valid;
    logic tx_first;
    logic tx_last;
    logic [7:0] tx_data;
    logic ack;
    logic [31:0] rdata;
    logic resp_valid;
    logic [7:0] rsp_cmd;
    logic [7:0] rsp_code;
    logic [7:0] rsp_pin;
    logic [1:0] rx_idx;
  } icch_host_t;
endpackage : icch_pkg
`default_nettype wire

// >>> design/icch_if.sv
// Byte-wide command and response link between host and device.
`default_nettype none
interface icch_if;
  logic h2d_valid;
  logic h2d_first;
  logic h2d_last;
  logic [7:0] h2d_data;
  logic d2h_valid;
  logic d2h_last;
  logic [7:0] d2h_data;
  modport host (output h2d_valid, output h2d_first, output h2d_last, output h2d_data,
                input d2h_valid, input d2h_last, input d2h_data);
  modport dev (input h2d_valid, input h2d_first, input h2d_last, input h2d_data,
               output d2h_valid, output d2h_last, output d2h_data);
endinterface : icch_if
`default_nettype wire

// >>> design/icch_le_asm.sv
// Little-endian assembler of argument bytes into one word.
`default_nettype none
module icch_le_asm (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Byte input
  input wire logic clr,
  input wire logic load,
  input wire logic [1:0] idx,
  input wire logic [7:0] din,
  // Assembled word
  output logic [31:0] word
);
  logic [31:0] word_reg;
  logic [31:0] word_next;

  always_comb begin
    word_next = word_reg;
    if (clr) begin
      word_next = 32'h00000000;
    end else if (load) begin
      word_next[8*idx +: 8] = din;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      word_reg <= 32'h00000000;
    end else begin
      word_reg <= word_next;
    end
  end

  assign word = word_reg;
endmodule : icch_le_asm
`default_nettype wire

// >>> design/icch_host.sv
// Host end: sends command frames ordered over Wishbone and captures responses.
`include "icch_cfg.svh"
`default_nettype none
module icch_host (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Command link
  icch_if.host lnk
);
  icch_pkg::icch_host_t r;
  icch_pkg::icch_host_t n;

  always_comb begin
    logic acc;
    acc = wb_cyc_i && wb_stb_i && !r.ack;
    n = r;
    n.ack = acc;
    n.tx_valid = 1'b0;
    n.tx_first = 1'b0;
    n.tx_last = 1'b0;
    // ****************************************************************
    // Register access
    // ****************************************************************
    if (acc && !wb_we_i) begin
      unique case (wb_adr_i)
        `ICCH_ADR_ARG: n.rdata = r.arg;
        `ICCH_ADR_STATUS: n.rdata = {r.rsp_cmd, r.rsp_pin, r.rsp_code, 6'h00, r.resp_valid,
                                     r.st == icch_pkg::HOST_SEND};
        default: n.rdata = 32'h00000000;
      endcase
    end
    if (acc && wb_we_i && wb_adr_i == `ICCH_ADR_ARG) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          n.arg[8*b +: 8] = wb_dat_i[8*b +: 8];
        end
      end
    end
    if (acc && wb_we_i && wb_adr_i == `ICCH_ADR_STATUS && wb_sel_i[0] && wb_dat_i[1]) begin
      n.resp_valid = 1'b0;
    end
    // ****************************************************************
    // Frame transmit
    // ****************************************************************
    unique case (r.st)
      icch_pkg::HOST_IDLE: begin
        // A go request while a frame is still leaving is dropped, not queued.
        if (acc && wb_we_i && wb_adr_i == `ICCH_ADR_CTRL && wb_sel_i == 4'hF && wb_dat_i[31]) begin
          n.cmd = wb_dat_i[7:0];
          n.nargs = wb_dat_i[10:8];
          n.idx = 3'h0;
          n.st = icch_pkg::HOST_SEND;
        end
      end
      icch_pkg::HOST_SEND: begin
        n.tx_valid = 1'b1;
        n.tx_first = r.idx == 3'h0;
        n.tx_data = r.idx == 3'h0 ? r.cmd : (r.idx <= 3'h4 ? r.arg[8*(r.idx-3'h1) +: 8] : 8'h00);
        n.tx_last = r.idx == r.nargs;
        n.idx = r.idx + 3'h1;
        if (n.tx_last) begin
          n.st = icch_pkg::HOST_IDLE;
        end
      end
    endcase
    // ****************************************************************
    // Response capture; a new response outranks a software clear.
    // ****************************************************************
    if (lnk.d2h_valid) begin
      unique case (r.rx_idx)
        2'h0: n.rsp_cmd = lnk.d2h_data;
        2'h1: n.rsp_code = lnk.d2h_data;
        default: n.rsp_pin = lnk.d2h_data;
      endcase
      if (r.rx_idx == 2'h0) begin
        n.rsp_pin = 8'h00;
      end
      n.rx_idx = lnk.d2h_last ? 2'h0 : (r.rx_idx == 2'h2 ? 2'h2 : r.rx_idx + 2'h1);
      if (lnk.d2h_last) begin
        n.resp_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '{st: icch_pkg::HOST_IDLE, default: '0};
    end else begin
      r <= n;
    end
  end

  assign wb_ack_o = r.ack;
  assign wb_dat_o = r.rdata;
  assign lnk.h2d_valid = r.tx_valid;
  assign lnk.h2d_first = r.tx_first;
  assign lnk.h2d_last = r.tx_last;
  assign lnk.h2d_data = r.tx_data;
endmodule : icch_host
`default_nettype wire

// >>> verification/icch_link_sva.sv
// Checker of the byte link between host and device ends.
`default_nettype none
module icch_link_sva (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Host to device
  input wire logic h2d_valid,
  input wire logic h2d_first,
  input wire logic h2d_last,
  input wire logic [7:0] h2d_data,
  // Device to host
  input wire logic d2h_valid,
  input wire logic d2h_last,
  input wire logic [7:0] d2h_data
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_frame_has_id: assert property ($rose(h2d_valid) |-> h2d_first) else $error("frame began without id");
  a_args_contig: assert property (h2d_valid && !h2d_last |=> h2d_valid && !h2d_first)
    else $error("argument bytes broke off");
  a_frame_ends: assert property (h2d_valid && h2d_last |=> !h2d_valid) else $error("byte after last");
  a_answer_time: assert property ($rose(d2h_valid) && d2h_data inside {[8'h30:8'h34]}
    |-> $past(h2d_valid && h2d_last, 3)) else $error("answer out of step");
  a_resp_short: assert property ($rose(d2h_valid) |-> ##[1:2] (d2h_valid && d2h_last))
    else $error("response too long");
  a_resp_contig: assert property (d2h_valid && !d2h_last |=> d2h_valid) else $error("response gap");
  a_pin_with_code: assert property ($rose(d2h_valid) ##1 (d2h_valid && !d2h_last)
    |-> d2h_data inside {8'h08, 8'h09}) else $error("pin byte with wrong code");
  a_plain_code_ends: assert property ($rose(d2h_valid) ##1 d2h_data inside {[8'h00:8'h07], 8'h0A, 8'h0B}
    |-> d2h_last) else $error("plain code not last");
  a_reset_report: assert property ($rose(d2h_valid) && d2h_data == 8'h40 |=> d2h_data == 8'h03 && d2h_last)
    else $error("reset report code wrong");
  cover property ($rose(d2h_valid) ##2 (d2h_valid && d2h_last));
  cover property ($rose(d2h_valid) && d2h_data == 8'h41);
  cover property (h2d_valid && h2d_first && h2d_data == 8'h33);
endmodule : icch_link_sva
`default_nettype wire

// >>> verification/test_interface_config_command_handler.sv
// Self-checking bench of both link ends driven over Wishbone.
`default_nettype none
module test_interface_config_command_handler;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, sys_rst, cyc, stb, we, ack, ack_enable, net_up, s_en, s_hi, s_sec, rreq;
  logic [7:0] adr, s_pin, m_fld;
  logic [31:0] dat, rdat, pin_in_use, pin_gpio_ok, q;
  logic [15:0] mem_avail, m_cnt;
  logic [1:0] u_en, u_pon, u_podd, u_stop, u_flow;
  logic [23:0] b0, b1;
  logic [15:0] mc_cnt [5] = '{16'd1025, 16'd8, 16'd8, 16'd33, 16'd32};
  logic [7:0] mc_fld [5] = '{8'h01, 8'h00, 8'h09, 8'h02, 8'h02};
  logic [7:0] mc_code [5] = '{8'h0A, 8'h0B, 8'h0B, 8'h05, 8'h00};
  int err_total, total_checks, cycles, pulses;
  icch_if lnk();
  icch_host icch_host_i (.mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .lnk(lnk));
  icch_device icch_device_i (.mclk(mclk), .sys_rst(sys_rst), .lnk(lnk), .ack_enable(ack_enable),
    .pin_in_use(pin_in_use), .pin_gpio_ok(pin_gpio_ok), .mem_avail(mem_avail), .net_up(net_up),
    .uart_interface_enable(u_en), .uart_parity_on(u_pon), .uart_parity_odd(u_podd), .uart_two_stop(u_stop),
    .uart_flow_control_enable(u_flow), .uart0_baud(b0), .first_uart_port_baud(b1), .spi_interface_enable(s_en),
    .spi_idle_high(s_hi), .spi_sample_second(s_sec), .spi_pending_pin(s_pin), .mcast_group_count(m_cnt),
    .mcast_addr_fields(m_fld), .sys_reset_req(rreq));
  icch_link_sva icch_link_sva_i (.mclk(mclk), .sys_rst(sys_rst), .h2d_valid(lnk.h2d_valid),
    .h2d_first(lnk.h2d_first), .h2d_last(lnk.h2d_last), .h2d_data(lnk.h2d_data), .d2h_valid(lnk.d2h_valid),
    .d2h_last(lnk.d2h_last), .d2h_data(lnk.d2h_data));
  // ****************************************************************
  // Bus and check tasks
  // ****************************************************************
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    if (err_total == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  // The wait for ack has no own limit; the cycle ceiling below cuts a hang short.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge mclk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic send(input logic [7:0] cmd, input logic [2:0] n, input logic [31:0] arg);
    wb(1'b1, 8'h04, arg);
    wb(1'b1, 8'h00, {1'b1, 20'h0, n, cmd});
  endtask : send
  task automatic poll(input logic [7:0] rid, input logic [7:0] code, input logic [7:0] pin);
    q = 32'h0;
    while (q[1] !== 1'b1) wb(1'b0, 8'h08, 32'h0);
    check(q[31:8], {rid, pin, code});
    wb(1'b1, 8'h08, 32'h2);
  endtask : poll
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (rreq === 1'b1) pulses++;
    if (cycles == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end
  initial begin
    {cyc, stb, we, net_up, adr, dat} = '0;
    {sys_rst, ack_enable, pin_in_use, pin_gpio_ok, mem_avail} = {2'b11, 32'h0, 32'hFFFFFFFF, 16'h0004};
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    check({u_en, b0, s_pin, m_fld}, {2'b11, 24'h01C200, 8'h0C, 8'h01});
    send(8'h30, 3'h4, {24'h012345, 8'hF1});
    poll(8'h30, 8'h00, 8'h00);
    check({u_en[0], u_pon[0], u_podd[0], u_stop[0], u_flow[0], b0}, {5'h1F, 24'h012345});
    send(8'h31, 3'h1, 32'h60);
    poll(8'h31, 8'h00, 8'h00);
    check({u_en[1], u_pon[1], u_podd[1], u_stop[1], b1}, {4'b0101, 24'h01C200});
    for (int i = 0; i < 8; i++) begin
      if (i != 1 && i != 4) begin
        send(8'h30, i[2:0], 32'h0);
        poll(8'h30, (i > 4) ? 8'h02 : 8'h01, 8'h00);
      end
    end
    pin_in_use <= 32'h40;
    send(8'h31, 3'h4, {24'h009600, 8'h81});
    poll(8'h31, 8'h09, 8'h06);
    check({u_en, u_flow, b0, b1}, {2'b01, 2'b01, 24'h012345, 24'h01C200});
    send(8'h32, 3'h2, {16'h0, 8'd40, 8'h31});
    poll(8'h32, 8'h08, 8'd40);
    send(8'h32, 3'h2, {16'h0, 8'd12, 8'h31});
    poll(8'h32, 8'h00, 8'h00);
    check({s_en, s_hi, s_sec, s_pin}, {3'b111, 8'd12});
    ack_enable <= 1'b0;
    send(8'h32, 3'h1, 32'h0);
    repeat (12) @(posedge mclk);
    wb(1'b0, 8'h08, 32'h0);
    check({q[1], s_en}, 2'b00);
    ack_enable <= 1'b1;
    send(8'h33, 3'h4, 32'hF85A23E0);
    poll(8'h33, 8'h07, 8'h00);
    send(8'h33, 3'h4, 32'hF85A23E1);
    poll(8'h40, 8'h03, 8'h00);
    check({pulses[7:0], b0}, {8'h01, 24'h01C200});
    net_up <= 1'b1;
    poll(8'h41, 8'h00, 8'h00);
    for (int i = 0; i < 5; i++) begin
      send(8'h34, 3'h3, {8'h0, mc_fld[i], mc_cnt[i]});
      poll(8'h34, mc_code[i], 8'h00);
    end
    check({pulses[7:0], m_cnt, m_fld}, {8'h02, 16'd32, 8'h02});
    tally_and_finish();
  end
endmodule : test_interface_config_command_handler
`default_nettype wire
